// file: asr_host.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// host controller driving the asynchronous static memory pins
module asr_host
  import asr_pkg::*;
(
  input  wire logic              CLK_SYS_IN,        // 10 MHz clock
  input  wire logic              SYS_RST_IN,        // sync reset, high
  // user side
  input  wire logic              REQ_VALID_IN,      // request present
  input  wire asr_req_t          REQ_IN,            // request fields
  output logic                   REQ_READY_OUT,     // request taken
  output logic                   RD_VALID_OUT,      // read data pulse
  output logic [DATA_W-1:0]      RD_DATA_OUT,       // read data
  input  wire logic              RETAIN_IN,         // hold in retention
  output logic                   RETAIN_BUSY_OUT,   // deselected for retention
  // memory side
  output asr_pins_t              MEM_PINS_OUT,      // control and address pins
  input  wire logic [DATA_W-1:0] MEM_DATA_IN,       // data pins sensed
  output logic [DATA_W-1:0]      MEM_DATA_OUT,      // data pins driven
  output logic [DATA_W-1:0]      MEM_DATA_OE_OUT    // data pin enables
);

  // ========================================================================
  // state machine
  typedef enum logic [5:0] {
    ST_IDLE    = 6'b000001,
    ST_RD      = 6'b000010,
    ST_WR      = 6'b000100,
    ST_WR_END  = 6'b001000,
    ST_RETAIN  = 6'b010000,
    ST_RECOVER = 6'b100000
  } asr_state_t;

  asr_state_t        state_q;
  asr_state_t        state_d;
  asr_pins_t         pins_q;
  asr_pins_t         pins_d;
  logic [DATA_W-1:0] wdata_q;
  logic [DATA_W-1:0] wdata_d;
  logic [1:0]        oe_lane_q;
  logic [1:0]        oe_lane_d;
  logic [DATA_W-1:0] rdata_q;
  logic              rvalid_q;
  logic [DATA_W-1:0] din_s1_q;
  logic [DATA_W-1:0] din_s2_q;
  logic [1:0]        rd_lanes_q;
  logic              retain_s1_q;
  logic              retain_s2_q;
  logic              cnt_load;
  logic [CNT_W-1:0]  cnt_value;
  logic              cnt_done;

  // ========================================================================
  // pin inputs through two flops
  always_ff @(posedge CLK_SYS_IN) begin
    din_s1_q    <= MEM_DATA_IN;
    din_s2_q    <= din_s1_q;
    retain_s1_q <= RETAIN_IN;
    retain_s2_q <= retain_s1_q;
  end

  // shared wait counter
  asr_wait_cnt u_wait (
    .clk_in   (CLK_SYS_IN),
    .rst_in   (SYS_RST_IN),
    .load_in  (cnt_load),
    .value_in (cnt_value),
    .done_out (cnt_done)
  );

  // ========================================================================
  // decode
  wire logic take_req  = (state_q == ST_IDLE) && REQ_VALID_IN && !retain_s2_q
                         && (REQ_IN.lanes != 2'b00);
  wire logic take_ret  = (state_q == ST_IDLE) && retain_s2_q;
  wire logic rd_finish = (state_q == ST_RD) && cnt_done;

  assign REQ_READY_OUT   = take_req;
  assign RETAIN_BUSY_OUT = (state_q == ST_RETAIN) || (state_q == ST_RECOVER);
  assign RD_VALID_OUT    = rvalid_q;
  assign RD_DATA_OUT     = rdata_q;
  assign MEM_PINS_OUT    = pins_q;
  assign MEM_DATA_OUT    = wdata_q;
  // lane enables from strobe low through the hold after write end, never during a read [RQ6]
  assign MEM_DATA_OE_OUT = {{8{oe_lane_q[1]}}, {8{oe_lane_q[0]}}};

  // ========================================================================
  // next state and pin values
  always_comb begin
    state_d   = state_q;
    pins_d    = pins_q;
    wdata_d   = wdata_q;
    oe_lane_d = oe_lane_q;
    cnt_load  = 1'b0;
    cnt_value = CNT_ZERO;
    unique case (state_q)
      ST_IDLE: begin
        pins_d = PINS_IDLE;                          // deselected, standby [RQ3] [RQ13]
        pins_d.address_pins = pins_q.address_pins;
        oe_lane_d = 2'b00;
        if (take_ret) begin
          state_d = ST_RETAIN;                       // deselect before supply drop [RQ14]
        end else if (take_req) begin
          pins_d.address_pins        = REQ_IN.addr;  // address set with select [RQ12] [RQ19]
          pins_d.select_low_active_n = 1'b0;         // both selects asserted [RQ4]
          pins_d.select_high_active  = 1'b1;
          pins_d.upper_lane_select_n = !REQ_IN.lanes[1];  // [RQ16] [RQ17]
          pins_d.lower_lane_select_n = !REQ_IN.lanes[0];
          if (REQ_IN.write) begin
            pins_d.write_strobe_n = 1'b0;            // strobe with select and lane [RQ1]
            pins_d.output_gate_n  = 1'b1;            // memory floats under strobe [RQ18]
            wdata_d   = REQ_IN.wdata;
            oe_lane_d = REQ_IN.lanes;                // drive only chosen lanes [RQ17]
            cnt_load  = 1'b1;
            cnt_value = CNT_W'(WE_LOW_CYC);          // width, setup, float [RQ2] [RQ7] [RQ12]
            state_d   = ST_WR;
          end else begin
            pins_d.write_strobe_n = 1'b1;
            pins_d.output_gate_n  = 1'b0;            // read: gate low [RQ10] [RQ11]
            cnt_load  = 1'b1;
            cnt_value = CNT_W'(RD_WAIT_CYC + 2);     // access plus sync stages [RQ8]
            state_d   = ST_RD;
          end
        end
      end
      ST_RD: begin
        if (cnt_done) begin
          pins_d = PINS_IDLE;                        // end read, address held [RQ9]
          pins_d.address_pins = pins_q.address_pins;
          state_d = ST_IDLE;                         // at least one idle cycle [RQ8]
        end
      end
      ST_WR: begin
        if (cnt_done) begin
          pins_d.write_strobe_n = 1'b1;              // strobe ends write [RQ1]
          pins_d.select_low_active_n = 1'b1;         // select ends with it, stays float [RQ5]
          pins_d.select_high_active  = 1'b0;
          cnt_load  = 1'b1;
          cnt_value = CNT_W'(WR_CYC);
          state_d   = ST_WR_END;
        end
      end
      ST_WR_END: begin
        if (cnt_done) begin
          oe_lane_d = 2'b00;                         // data hold after end, address kept [RQ20]
          pins_d.upper_lane_select_n = 1'b1;
          pins_d.lower_lane_select_n = 1'b1;
          state_d = ST_IDLE;
        end
      end
      ST_RETAIN: begin
        pins_d = PINS_IDLE;                          // select held off [RQ14] [RQ15]
        if (!retain_s2_q) begin
          cnt_load  = 1'b1;
          cnt_value = CNT_W'(RECOVER_CYC);
          state_d   = ST_RECOVER;
        end
      end
      ST_RECOVER: begin
        if (cnt_done) begin
          state_d = ST_IDLE;                         // recovery time elapsed [RQ14]
        end
      end
      default: begin
        state_d = ST_IDLE;
        pins_d  = PINS_IDLE;
        oe_lane_d = 2'b00;
      end
    endcase
  end

  // ========================================================================
  // state and pin registers
  always_ff @(posedge CLK_SYS_IN) begin
    if (SYS_RST_IN) begin
      state_q   <= ST_IDLE;
      pins_q    <= PINS_IDLE;
      wdata_q   <= '0;
      oe_lane_q <= 2'b00;
    end else begin
      state_q   <= state_d;
      pins_q    <= pins_d;
      wdata_q   <= wdata_d;
      oe_lane_q <= oe_lane_d;
    end
  end

  // lanes of current read
  always_ff @(posedge CLK_SYS_IN) begin
    if (SYS_RST_IN) begin
      rd_lanes_q <= 2'b00;
    end else if (take_req) begin
      rd_lanes_q <= REQ_IN.lanes;
    end
  end

  // read capture, unselected lanes read zero
  always_ff @(posedge CLK_SYS_IN) begin
    if (SYS_RST_IN) begin
      rdata_q  <= '0;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= rd_finish;
      if (rd_finish) begin
        rdata_q <= din_s2_q & {{8{rd_lanes_q[1]}}, {8{rd_lanes_q[0]}}};  // [RQ16]
      end
    end
  end

endmodule
`default_nettype wire

// file: asr_pkg.sv
// ==========================================================================
// Operation
// [RQ1] write needs strobe, select, lane together
// [RQ2] data setup 25 ns before write end
// [RQ3] deselect when select or both lanes off
// [RQ4] dual select: low-active low, high-active high
// [RQ5] select and strobe ending together stays floating
// [RQ6] never drive pins while memory drives them
// [RQ7] strobe low covers setup plus float delay
// [RQ8] reads 45 ns apart, data valid 45 ns
// [RQ9] old data held 10 ns after address change
// [RQ10] output gate to data 22 ns, drive 5 ns
// [RQ11] lane select to drive at least 5 ns
// [RQ12] write cycle 45, widths 35, setup/hold 0
// [RQ13] power up at select, standby within 45 ns
// [RQ14] retention: deselect, keep 45 ns after restore
// [RQ15] strobe and gate high: pins float
// [RQ16] lower lane bits 0-7, upper 8-15 on read
// [RQ17] write stores only selected lanes
// [RQ18] selected with strobe low: memory floats
// [RQ19] 262144 words of 16 bits, 18-bit address
// [RQ20] address stable through whole write
package asr_pkg;

  // ========================================================================
  // widths
  localparam int ADDR_W = 18;
  localparam int DATA_W = 16;

  // ========================================================================
  // timing in ns and derived cycle counts at 100 ns clock
  localparam int CLK_PERIOD_NS  = 100;
  localparam int T_READ_CYC_NS  = 45;   // read cycle and access time
  localparam int T_WRITE_CYC_NS = 45;   // write cycle
  localparam int T_WE_WIDTH_NS  = 35;   // strobe width and select-to-end
  localparam int T_SETUP_NS     = 25;   // data setup to write end
  localparam int T_FLOAT_NS     = 18;   // strobe low to memory float
  localparam int T_RECOVER_NS   = 45;   // retention recovery
  localparam int T_STANDBY_NS   = 45;   // select high to standby

  // least times round up, none below one cycle
  function automatic int ceil_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int RD_WAIT_CYC  = ceil_cyc(T_READ_CYC_NS);
  localparam int WE_LOW_CYC   = ceil_cyc(T_WE_WIDTH_NS + T_SETUP_NS + T_FLOAT_NS);
  localparam int WR_CYC       = ceil_cyc(T_WRITE_CYC_NS);
  localparam int RECOVER_CYC  = ceil_cyc(T_RECOVER_NS);
  localparam int CNT_W        = 4;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;

  // ========================================================================
  // request and pin carriers
  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [1:0]        lanes;   // bit1 upper, bit0 lower, active high
  } asr_req_t;

  typedef struct packed {
    logic [ADDR_W-1:0] address_pins;
    logic              select_low_active_n;
    logic              select_high_active;
    logic              write_strobe_n;
    logic              output_gate_n;
    logic              upper_lane_select_n;
    logic              lower_lane_select_n;
  } asr_pins_t;

  localparam asr_pins_t PINS_IDLE = '{
    address_pins: '0, select_low_active_n: 1'b1, select_high_active: 1'b0,
    write_strobe_n: 1'b1, output_gate_n: 1'b1,
    upper_lane_select_n: 1'b1, lower_lane_select_n: 1'b1};

endpackage

// file: asr_wait_cnt.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// down counter: load, then done when zero
module asr_wait_cnt
  import asr_pkg::*;
(
  input  wire logic             clk_in,    // system clock
  input  wire logic             rst_in,    // sync reset
  input  wire logic             load_in,   // load count
  input  wire logic [CNT_W-1:0] value_in,  // count to load
  output logic                  done_out   // count at zero
);
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;

  // next count
  assign cnt_d    = load_in ? value_in : ((cnt_q != CNT_ZERO) ? cnt_q - 4'h1 : cnt_q);
  assign done_out = (cnt_q == CNT_ZERO);

  // count register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_q <= CNT_ZERO;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule
`default_nettype wire

// file: asr_host_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// pin protocol checks on the host controller
module asr_host_sva
  import asr_pkg::*;
(
  input wire logic              CLK_SYS_IN,      // clock
  input wire logic              SYS_RST_IN,      // reset
  input wire logic              REQ_VALID_IN,    // request present
  input wire asr_req_t          REQ_IN,          // request fields
  input wire logic              REQ_READY_OUT,   // request taken
  input wire logic              RD_VALID_OUT,    // read pulse
  input wire logic              RETAIN_BUSY_OUT, // retention
  input wire asr_pins_t         MEM_PINS_OUT,    // memory pins
  input wire logic [DATA_W-1:0] MEM_DATA_OUT,    // write data
  input wire logic [DATA_W-1:0] MEM_DATA_OE_OUT  // data enables
);
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (SYS_RST_IN);
  // pin aliases
  wire logic              we_n  = MEM_PINS_OUT.write_strobe_n;
  wire logic              oe_n  = MEM_PINS_OUT.output_gate_n;
  wire logic              cs_n  = MEM_PINS_OUT.select_low_active_n;
  wire logic              cs_hi = MEM_PINS_OUT.select_high_active;
  wire logic [DATA_W-1:0] lmask = {{8{~MEM_PINS_OUT.upper_lane_select_n}},
                                   {8{~MEM_PINS_OUT.lower_lane_select_n}}};
  // ========================================================================
  // assertions
  a_write_lane_drive: assert property (!we_n |-> MEM_DATA_OE_OUT == lmask && !cs_n)
    else $error("write drive does not follow lanes");
  a_read_no_drive: assert property (!oe_n |-> MEM_DATA_OE_OUT == '0 && we_n)
    else $error("host drives during read");
  a_dual_select: assert property (cs_n == !cs_hi)
    else $error("select pair disagrees");
  a_strobe_width: assert property ($fell(we_n) |=> !we_n)
    else $error("strobe too short");
  a_data_setup: assert property (!we_n && !$fell(we_n) |-> $stable(MEM_DATA_OUT))
    else $error("write data moved under strobe");
  a_addr_hold: assert property ((!we_n || $rose(we_n)) && !$fell(we_n)
    |-> $stable(MEM_PINS_OUT.address_pins))
    else $error("address moved in write");
  a_write_end_desel: assert property ($rose(we_n) |-> cs_n)
    else $error("write end without deselect");
  a_read_latency: assert property (REQ_VALID_IN && REQ_READY_OUT && !REQ_IN.write
    |-> ##5 RD_VALID_OUT ##1 !RD_VALID_OUT)
    else $error("read answer late");
  a_take_lanes: assert property (REQ_READY_OUT |-> REQ_IN.lanes != 2'b00 && !RETAIN_BUSY_OUT)
    else $error("bad request taken");
  a_retain_desel: assert property (RETAIN_BUSY_OUT |-> cs_n && !cs_hi)
    else $error("selected in retention");
endmodule
bind asr_host asr_host_sva asr_host_sva_inst (.CLK_SYS_IN(CLK_SYS_IN),
  .SYS_RST_IN(SYS_RST_IN), .REQ_VALID_IN(REQ_VALID_IN), .REQ_IN(REQ_IN),
  .REQ_READY_OUT(REQ_READY_OUT), .RD_VALID_OUT(RD_VALID_OUT),
  .RETAIN_BUSY_OUT(RETAIN_BUSY_OUT), .MEM_PINS_OUT(MEM_PINS_OUT),
  .MEM_DATA_OUT(MEM_DATA_OUT), .MEM_DATA_OE_OUT(MEM_DATA_OE_OUT));
`default_nettype wire

// file: asr_sram_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// static memory model on the far side of the pins
module asr_sram_model
  import asr_pkg::*;
(
  input  wire logic              clk_in,     // bench clock
  input  wire asr_pins_t         pins_in,    // control and address
  input  wire logic [DATA_W-1:0] host_in,    // host data
  input  wire logic [DATA_W-1:0] host_oe_in, // host enables
  output logic      [DATA_W-1:0] bus_out,    // resolved data pins
  output logic                   clash_out   // both sides drove
);
  logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
  logic [DATA_W-1:0] rd, drv, drv_dly;
  logic              tick = 1'b0;
  wire logic ce = ~pins_in.select_low_active_n & pins_in.select_high_active;
  wire logic [ADDR_W-1:0] a  = pins_in.address_pins;
  wire logic [DATA_W-1:0] wm = {{8{~pins_in.upper_lane_select_n}},
                                {8{~pins_in.lower_lane_select_n}}};
  initial clash_out = 1'b0;
  // read drive per selected lane, only strobe high and gate low
  assign drv = wm & {DATA_W{ce & pins_in.write_strobe_n & ~pins_in.output_gate_n}};
  // late turn-on, drive held 10 ns after change
  assign #10 drv_dly = drv;
  // stored word, refreshed on address change and after every edge's store
  always @(a, tick) rd = mem.exists(a) ? mem[a] : 16'h0000;
  // undriven bits toggle every cycle
  always_comb for (int i = 0; i < DATA_W; i++) begin
    bus_out[i] = host_oe_in[i] ? host_in[i] : (drv_dly[i] ? rd[i] : tick ^ i[0]);
  end
  // store selected lanes while write overlap holds
  always @(posedge clk_in) begin
    tick <= ~tick;
    if (ce && !pins_in.write_strobe_n && wm != 16'h0000) mem[a] = (rd & ~wm) | (bus_out & wm);
    if (|(drv_dly & host_oe_in)) clash_out <= 1'b1;
  end
endmodule
`default_nettype wire

// file: async_sram_word_byte_access_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// bench for the host controller and memory model
module async_sram_word_byte_access_tb_top
  import asr_pkg::*;
();
  logic clk = 1'b0, rst = 1'b1, req_valid = 1'b0, retain = 1'b0;
  logic ready, rd_valid, busy, clash;
  asr_req_t req = '0;
  asr_pins_t pins;
  logic [DATA_W-1:0] rd_data, dout, doe, bus;
  logic [15:0] ref_mem [logic [17:0]];
  logic [31:0] rnd = 32'h077A7760;
  int fail_count = 0, checks_done = 0;
  always #50 clk = ~clk;
  asr_host asr_host_inst (.CLK_SYS_IN(clk), .SYS_RST_IN(rst), .REQ_VALID_IN(req_valid),
    .REQ_IN(req), .REQ_READY_OUT(ready), .RD_VALID_OUT(rd_valid), .RD_DATA_OUT(rd_data),
    .RETAIN_IN(retain), .RETAIN_BUSY_OUT(busy), .MEM_PINS_OUT(pins), .MEM_DATA_IN(bus),
    .MEM_DATA_OUT(dout), .MEM_DATA_OE_OUT(doe));
  asr_sram_model asr_sram_model_inst (.clk_in(clk), .pins_in(pins), .host_in(dout),
    .host_oe_in(doe), .bus_out(bus), .clash_out(clash));
  // ========================================================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
  endfunction
  function automatic logic [15:0] ref_rd(input logic [17:0] a);
    return ref_mem.exists(a) ? ref_mem[a] : 16'h0000;
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic access(input logic w, input logic [17:0] a, input logic [15:0] d,
                        input logic [1:0] l);
    int n;
    logic [15:0] m;
    @(posedge clk);
    req <= '{write: w, addr: a, wdata: d, lanes: l};
    req_valid <= 1'b1;
    n = 0;
    do begin @(negedge clk); n++; end while (ready !== 1'b1 && n < 50);
    chk("ready", 16'h1, 16'(ready));
    @(posedge clk);
    req_valid <= 1'b0;
    m = {{8{l[1]}}, {8{l[0]}}};
    if (w) ref_mem[a] = (ref_rd(a) & ~m) | (d & m);
    else begin
      n = 0;
      do begin @(negedge clk); n++; end while (rd_valid !== 1'b1 && n < 20);
      chk("rd_valid", 16'h1, 16'(rd_valid));
      chk("rd_data", ref_rd(a) & m, rd_data);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ========================================================================
  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    stop_test();
  end
  // ========================================================================
  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    // address extremes and every nonzero lane code
    access(1'b1, 18'h00000, 16'hA55A, 2'b11);
    access(1'b1, 18'h3FFFF, 16'h1234, 2'b11);
    for (int l = 1; l < 4; l++) begin
      access(1'b1, 18'h3FFFF, 16'hC3E1 ^ 16'(l), 2'(l));
      for (int k = 1; k < 4; k++) access(1'b0, 18'h3FFFF, 16'h0000, 2'(k));
    end
    access(1'b0, 18'h00000, 16'h0000, 2'b11);
    $display("test lanes done");
    // no lanes selected is never taken
    @(posedge clk);
    req <= '{write: 1'b1, addr: 18'h00010, wdata: 16'hFFFF, lanes: 2'b00};
    req_valid <= 1'b1;
    repeat (8) begin @(negedge clk); chk("ready_nolane", 16'h0, 16'(ready)); end
    @(posedge clk);
    req_valid <= 1'b0;
    $display("test refuse done");
    // retention keeps contents and refuses requests
    retain <= 1'b1;
    repeat (4) @(posedge clk);
    req <= '{write: 1'b0, addr: 18'h00000, wdata: 16'h0, lanes: 2'b11};
    req_valid <= 1'b1;
    repeat (4) begin
      @(negedge clk);
      chk("retain_busy", 16'h1, 16'(busy));
      chk("retain_sel", 16'h1, 16'(pins.select_low_active_n));
      chk("ready_retain", 16'h0, 16'(ready));
    end
    @(posedge clk);
    req_valid <= 1'b0;
    retain <= 1'b0;
    repeat (6) @(posedge clk);
    chk("busy_end", 16'h0, 16'(busy));
    access(1'b0, 18'h00000, 16'h0000, 2'b11);
    $display("test retention done");
    // random traffic over a small address window
    for (int i = 0; i < 60; i++) begin
      rnd = lfsr(rnd);
      access(rnd[0], {14'h0ABC, rnd[4:1]}, rnd[31:16], (rnd[6:5] == 2'b00) ? 2'b11 : rnd[6:5]);
    end
    $display("test random done");
    chk("no_clash", 16'h0, 16'(clash));
    stop_test();
  end
endmodule
`default_nettype wire
